// File: design/tpio_regs.svh
// register indices, field positions and reset values of the pin i/o decoder
`ifndef TPIO_REGS_SVH
`define TPIO_REGS_SVH
// register index = haddr[4:2]; byte address = 4 * index
`define TPIO_IDX_IO_CH5   3'h0
`define TPIO_IDX_IO_HI0   3'h1
`define TPIO_IDX_IO_LO0   3'h2
`define TPIO_IDX_GR_B5    3'h3
`define TPIO_IDX_GR_A0    3'h4
`define TPIO_IDX_GR_C0    3'h5
`define TPIO_IDX_CTRL     3'h6
// field positions
`define TPIO_B5_HI        7
`define TPIO_B5_LO        4
`define TPIO_CH0_HI       3
`define TPIO_CH0_LO       0
`define TPIO_FLD_CAPT     3
`define TPIO_FLD_INIT     2
`define TPIO_FLD_CASC     2
`define TPIO_CTRL_BUFA    0
`define TPIO_CTRL_PSC_HI  3
`define TPIO_CTRL_PSC_LO  1
`define TPIO_CTRL_PIN_LO  8
`define TPIO_CTRL_OE_LO   12
`define TPIO_PSC_UNDIV    3'h0
`define TPIO_RST_CTL      8'h00
`define TPIO_RST_GR       16'h0000
`endif

// File: design/tpio_pkg.sv
// types of the timer pin i/o decoder
package tpio_pkg;
	typedef enum logic [1:0] {
		TPIO_ACT_OFF  = 2'b00,
		TPIO_ACT_LOW  = 2'b01,
		TPIO_ACT_HIGH = 2'b10,
		TPIO_ACT_TOG  = 2'b11
	} tpio_act_e;
	typedef enum logic [1:0] {
		TPIO_EDGE_RISE = 2'b00,
		TPIO_EDGE_FALL = 2'b01,
		TPIO_EDGE_BTH0 = 2'b10,
		TPIO_EDGE_BTH1 = 2'b11
	} tpio_edge_e;
	// channel 0: ch5 b, 1: ch0 a, 2: ch0 c
	typedef struct packed {
		logic [2:0]       pin;
		logic [2:0]       oe;
	} tpio_pins_s;
	typedef struct packed {
		logic [2:0][7:0]  ctl;
		logic [2:0][15:0] gr;
		logic [1:0][15:0] cq;
		logic             bufa;
		logic [2:0]       psc;
		logic [2:0]       s1;
		logic [2:0]       s2;
		logic [2:0]       prev;
		tpio_pins_s       io;
		logic             wr_pend;
		logic             rd_pend;
		logic             ok;
		logic [2:0]       idx;
		logic             hready;
		logic [31:0]      hrdata;
	} tpio_state_s;
endpackage

// File: design/tpio_top.sv
// timer pin i/o mode decode: compare outputs and capture inputs, AHB-Lite slave
`timescale 1ns/100ps
`include "tpio_regs.svh"
// What this block does
// - ch5 field in bits 7:4, bit 6 ignored in capture mode
// - ch0 A/C fields in bits 3:0
// - top bit 0: compare, init level, 00 off, 01 low
// - low bits 10 drive pin high on match
// - low bits 11 toggle pin on match
// - 1000 captures own pin rising edge
// - 1001 captures own pin falling edge
// - 101x captures own pin both edges
// - ch0 11xx captures on channel one count
// - undivided channel one clock makes cascade invalid
// - C buffer mode kills C compare and capture
module tpio_top (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// counters and channel one count tick, same clock
	input  wire logic [15:0] counter_ch5,
	input  wire logic [15:0] counter_ch0,
	input  wire logic        counter_ch1_tick,
	// timer pins: [0] pin_b_ch5, [1] pin_a_ch0, [2] pin_c_ch0
	input  wire logic [2:0]  pin_in,
	output tpio_pkg::tpio_pins_s pin_io
);
	tpio_pkg::tpio_state_s st;
	tpio_pkg::tpio_state_s next_st;
	logic [2:0][3:0]  fld;
	logic [2:0][3:0]  nfld;
	logic [2:0][15:0] cnt;
	logic [2:0]       rise;
	logic [2:0]       fall;
	logic [2:0]       cap_ev;
	logic [2:0]       match;
	logic [2:0]       wf;
	logic [2:0]       dis;
	logic             acc;
	logic             mapped;
	logic             casc_ok;

	assign fld[0] = st.ctl[0][`TPIO_B5_HI:`TPIO_B5_LO];
	assign fld[1] = st.ctl[1][`TPIO_CH0_HI:`TPIO_CH0_LO];
	assign fld[2] = st.ctl[2][`TPIO_CH0_HI:`TPIO_CH0_LO];
	assign cnt[0] = counter_ch5;
	assign cnt[1] = counter_ch0;
	assign cnt[2] = counter_ch0;
	assign rise = st.s2 & ~st.prev;
	assign fall = ~st.s2 & st.prev;
	assign dis = {st.bufa, 2'b00};
	// undivided clock feeds channel one: cascade would see every cycle
	assign casc_ok = counter_ch1_tick && (st.psc != `TPIO_PSC_UNDIV);
	assign wf[0] = st.wr_pend && (st.idx == `TPIO_IDX_IO_CH5);
	assign wf[1] = st.wr_pend && (st.idx == `TPIO_IDX_IO_HI0);
	assign wf[2] = st.wr_pend && (st.idx == `TPIO_IDX_IO_LO0);
	assign acc = hsel && htrans[1] && hready;
	assign mapped = (haddr[31:5] == 27'h0000000) && (haddr[1:0] == 2'h0)
		&& (haddr[4:2] <= `TPIO_IDX_CTRL);

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			// counter must move onto the value, so a stalled counter matches once
			match[i] = !fld[i][`TPIO_FLD_CAPT] && (cnt[i] == st.gr[i])
				&& (cnt[i] != st.cq[(i == 0) ? 0 : 1]);
			if (!fld[i][`TPIO_FLD_CAPT] || dis[i]) begin
				cap_ev[i] = 1'b0;
			end else if (i != 0 && fld[i][`TPIO_FLD_CASC]) begin
				cap_ev[i] = casc_ok;
			end else begin
				unique case (tpio_pkg::tpio_edge_e'(fld[i][1:0]))
					tpio_pkg::TPIO_EDGE_RISE: cap_ev[i] = rise[i];
					tpio_pkg::TPIO_EDGE_FALL: cap_ev[i] = fall[i];
					tpio_pkg::TPIO_EDGE_BTH0,
					tpio_pkg::TPIO_EDGE_BTH1: cap_ev[i] = rise[i] | fall[i];
				endcase
			end
		end
	end

	always_comb begin
		next_st = st;
		next_st.s1 = pin_in;
		next_st.s2 = st.s1;
		next_st.prev = st.s2;
		next_st.cq[0] = counter_ch5;
		next_st.cq[1] = counter_ch0;
		// register writes, data phase of an accepted write
		if (st.wr_pend) begin
			unique case (st.idx)
				`TPIO_IDX_IO_CH5: next_st.ctl[0] = hwdata[7:0];
				`TPIO_IDX_IO_HI0: next_st.ctl[1] = hwdata[7:0];
				`TPIO_IDX_IO_LO0: next_st.ctl[2] = hwdata[7:0];
				`TPIO_IDX_GR_B5:  next_st.gr[0] = hwdata[15:0];
				`TPIO_IDX_GR_A0:  next_st.gr[1] = hwdata[15:0];
				`TPIO_IDX_GR_C0:  next_st.gr[2] = hwdata[15:0];
				`TPIO_IDX_CTRL: begin
					next_st.bufa = hwdata[`TPIO_CTRL_BUFA];
					next_st.psc = hwdata[`TPIO_CTRL_PSC_HI:`TPIO_CTRL_PSC_LO];
				end
				default: next_st.bufa = st.bufa;
			endcase
		end
		nfld[0] = next_st.ctl[0][`TPIO_B5_HI:`TPIO_B5_LO];
		nfld[1] = next_st.ctl[1][`TPIO_CH0_HI:`TPIO_CH0_LO];
		nfld[2] = next_st.ctl[2][`TPIO_CH0_HI:`TPIO_CH0_LO];
		for (int i = 0; i < 3; i++) begin
			// capture after the write: hardware event wins over software
			if (cap_ev[i]) begin
				next_st.gr[i] = cnt[i];
			end
			if (wf[i] && !nfld[i][`TPIO_FLD_CAPT]) begin
				next_st.io.pin[i] = nfld[i][`TPIO_FLD_INIT];
			end else if (match[i] && !dis[i]) begin
				unique case (tpio_pkg::tpio_act_e'(fld[i][1:0]))
					tpio_pkg::TPIO_ACT_OFF:  next_st.io.pin[i] = st.io.pin[i];
					tpio_pkg::TPIO_ACT_LOW:  next_st.io.pin[i] = 1'b0;
					tpio_pkg::TPIO_ACT_HIGH: next_st.io.pin[i] = 1'b1;
					tpio_pkg::TPIO_ACT_TOG:  next_st.io.pin[i] = !st.io.pin[i];
				endcase
			end
			next_st.io.oe[i] = !nfld[i][`TPIO_FLD_CAPT] && (nfld[i][1:0] != 2'b00)
				&& !(i == 2 && next_st.bufa);
		end
		// bus: writes take no wait, reads one wait state
		next_st.wr_pend = acc && hwrite && mapped;
		next_st.rd_pend = acc && !hwrite;
		next_st.ok = mapped;
		next_st.idx = haddr[4:2];
		next_st.hready = !(acc && !hwrite);
		if (st.rd_pend) begin
			next_st.hready = 1'b1;
			next_st.hrdata = 32'h00000000;
			if (st.ok) begin
				unique case (st.idx)
					`TPIO_IDX_IO_CH5: next_st.hrdata[7:0] = st.ctl[0];
					`TPIO_IDX_IO_HI0: next_st.hrdata[7:0] = st.ctl[1];
					`TPIO_IDX_IO_LO0: next_st.hrdata[7:0] = st.ctl[2];
					`TPIO_IDX_GR_B5:  next_st.hrdata[15:0] = st.gr[0];
					`TPIO_IDX_GR_A0:  next_st.hrdata[15:0] = st.gr[1];
					`TPIO_IDX_GR_C0:  next_st.hrdata[15:0] = st.gr[2];
					`TPIO_IDX_CTRL: begin
						next_st.hrdata[`TPIO_CTRL_BUFA] = st.bufa;
						next_st.hrdata[`TPIO_CTRL_PSC_HI:`TPIO_CTRL_PSC_LO] = st.psc;
						next_st.hrdata[`TPIO_CTRL_PIN_LO +: 3] = st.io.pin;
						next_st.hrdata[`TPIO_CTRL_OE_LO +: 3] = st.io.oe;
					end
					default: next_st.hrdata = 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st <= '0;
			st.ctl <= {3{`TPIO_RST_CTL}};
			st.gr <= {3{`TPIO_RST_GR}};
			st.hready <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign hreadyout = st.hready;
	assign hresp = 1'b0;
	assign hrdata = st.hrdata;
	assign pin_io = st.io;

	AST_CH5_BIT6_IGNORED: assert property (@(posedge clk) disable iff (reset)
		(fld[0] == 4'hC && rise[0]) |=> (st.gr[0] == $past(counter_ch5)))
		else $error("ch5 capture with bit 6 set missed");
	AST_FIELD_A_WRITE: assert property (@(posedge clk) disable iff (reset)
		(st.wr_pend && st.idx == `TPIO_IDX_IO_HI0) |=> (fld[1] == $past(hwdata[3:0])))
		else $error("field a not taken from bits 3:0");
	AST_MATCH_LOW: assert property (@(posedge clk) disable iff (reset)
		(match[1] && fld[1][1:0] == 2'b01 && !wf[1]) |=> (pin_io.pin[1] == 1'b0))
		else $error("match did not drive pin low");
	AST_MATCH_HIGH: assert property (@(posedge clk) disable iff (reset)
		(match[0] && fld[0][1:0] == 2'b10 && !wf[0]) |=> (pin_io.pin[0] == 1'b1))
		else $error("match did not drive pin high");
	AST_MATCH_TOGGLE: assert property (@(posedge clk) disable iff (reset)
		(match[1] && fld[1][1:0] == 2'b11 && !wf[1]) |=> (pin_io.pin[1] != $past(pin_io.pin[1])))
		else $error("match did not toggle pin");
	AST_OUT_DISABLED: assert property (@(posedge clk) disable iff (reset)
		(fld[0][3] == 1'b0 && fld[0][1:0] == 2'b00) |-> !pin_io.oe[0])
		else $error("pin driven with output disabled");
	AST_RISE_CAPTURE: assert property (@(posedge clk) disable iff (reset)
		(fld[1] == 4'h8 && $rose(st.s2[1])) |=> (st.gr[1] == $past(counter_ch0)))
		else $error("rising edge capture missed");
	AST_FALL_CAPTURE: assert property (@(posedge clk) disable iff (reset)
		(fld[1] == 4'h9 && rise[1]) |=> $stable(st.gr[1])
		|| $past(st.wr_pend && st.idx == `TPIO_IDX_GR_A0))
		else $error("falling mode captured a rising edge");
	AST_BOTH_CAPTURE: assert property (@(posedge clk) disable iff (reset)
		(fld[0][3:1] == 3'b101 && fall[0]) |=> (st.gr[0] == $past(counter_ch5)))
		else $error("both edge capture missed a fall");
	AST_CASCADE: assert property (@(posedge clk) disable iff (reset)
		(fld[1][3:2] == 2'b11 && counter_ch1_tick && st.psc != 3'h0)
		|=> (st.gr[1] == $past(counter_ch0)))
		else $error("cascade capture missed");
	AST_CASCADE_UNDIV: assert property (@(posedge clk) disable iff (reset)
		(fld[1][3:2] == 2'b11 && st.psc == 3'h0 && !st.wr_pend) |=> $stable(st.gr[1]))
		else $error("cascade captured on undivided clock");
	AST_BUFFER_C: assert property (@(posedge clk) disable iff (reset)
		st.bufa |-> !pin_io.oe[2] && !cap_ev[2])
		else $error("c field active in buffer mode");
	AST_INIT_ON_WRITE: assert property (@(posedge clk) disable iff (reset)
		(wf[2] && !hwdata[3]) |=> (pin_io.pin[2] == $past(hwdata[2])))
		else $error("initial level not applied on write");
	AST_READ_WAIT: assert property (@(posedge clk) disable iff (reset)
		(acc && !hwrite) |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	AST_CH5_FIELD_WRITE: assert property (@(posedge clk) disable iff (reset)
		(st.wr_pend && st.idx == `TPIO_IDX_IO_CH5) |=> (fld[0] == $past(hwdata[7:4])))
		else $error("field b not taken from bits 7:4");
	AST_FIELD_C_WRITE: assert property (@(posedge clk) disable iff (reset)
		(st.wr_pend && st.idx == `TPIO_IDX_IO_LO0) |=> (fld[2] == $past(hwdata[3:0])))
		else $error("field c not taken from bits 3:0");
	AST_MATCH_LOW_B5: assert property (@(posedge clk) disable iff (reset)
		(match[0] && fld[0][1:0] == 2'b01 && !wf[0]) |=> (pin_io.pin[0] == 1'b0))
		else $error("match did not drive b pin low");
	AST_MATCH_LOW_C0: assert property (@(posedge clk) disable iff (reset)
		(match[2] && fld[2][1:0] == 2'b01 && !wf[2] && !dis[2]) |=> (pin_io.pin[2] == 1'b0))
		else $error("match did not drive c pin low");
	AST_MATCH_HIGH_A0: assert property (@(posedge clk) disable iff (reset)
		(match[1] && fld[1][1:0] == 2'b10 && !wf[1]) |=> (pin_io.pin[1] == 1'b1))
		else $error("match did not drive a pin high");
	AST_MATCH_HIGH_C0: assert property (@(posedge clk) disable iff (reset)
		(match[2] && fld[2][1:0] == 2'b10 && !wf[2] && !dis[2]) |=> (pin_io.pin[2] == 1'b1))
		else $error("match did not drive c pin high");
	AST_MATCH_TOGGLE_B5: assert property (@(posedge clk) disable iff (reset)
		(match[0] && fld[0][1:0] == 2'b11 && !wf[0]) |=> (pin_io.pin[0] != $past(pin_io.pin[0])))
		else $error("match did not toggle b pin");
	AST_MATCH_TOGGLE_C0: assert property (@(posedge clk) disable iff (reset)
		(match[2] && fld[2][1:0] == 2'b11 && !wf[2] && !dis[2])
		|=> (pin_io.pin[2] != $past(pin_io.pin[2])))
		else $error("match did not toggle c pin");
	AST_OUT_DISABLED_A0: assert property (@(posedge clk) disable iff (reset)
		(fld[1][3] == 1'b0 && fld[1][1:0] == 2'b00) |-> !pin_io.oe[1])
		else $error("a pin driven with output disabled");
	AST_OUT_DISABLED_C0: assert property (@(posedge clk) disable iff (reset)
		(fld[2][3] == 1'b0 && fld[2][1:0] == 2'b00) |-> !pin_io.oe[2])
		else $error("c pin driven with output disabled");
	AST_OUT_ENABLED_B5: assert property (@(posedge clk) disable iff (reset)
		(fld[0][3] == 1'b0 && fld[0][1:0] != 2'b00) |-> pin_io.oe[0])
		else $error("b pin not driven in compare mode");
	AST_CAPTURE_NO_DRIVE: assert property (@(posedge clk) disable iff (reset)
		fld[1][3] |-> !pin_io.oe[1])
		else $error("a pin driven in capture mode");
	AST_RISE_CAPTURE_C0: assert property (@(posedge clk) disable iff (reset)
		(fld[2] == 4'h8 && rise[2] && !dis[2]) |=> (st.gr[2] == $past(counter_ch0)))
		else $error("c rising edge capture missed");
	AST_FALL_CAPTURE_A0: assert property (@(posedge clk) disable iff (reset)
		(fld[1] == 4'h9 && fall[1]) |=> (st.gr[1] == $past(counter_ch0)))
		else $error("a falling edge capture missed");
	AST_FALL_CAPTURE_B5: assert property (@(posedge clk) disable iff (reset)
		(fld[0][3] && fld[0][1:0] == 2'b01 && fall[0]) |=> (st.gr[0] == $past(counter_ch5)))
		else $error("b falling edge capture missed");
	AST_BOTH_CAPTURE_A0: assert property (@(posedge clk) disable iff (reset)
		(fld[1][3:1] == 3'b101 && rise[1]) |=> (st.gr[1] == $past(counter_ch0)))
		else $error("both edge capture missed a rise");
	AST_CASCADE_C0: assert property (@(posedge clk) disable iff (reset)
		(fld[2][3:2] == 2'b11 && counter_ch1_tick && st.psc != `TPIO_PSC_UNDIV && !dis[2])
		|=> (st.gr[2] == $past(counter_ch0)))
		else $error("c cascade capture missed");
	AST_CH5_NO_CASCADE: assert property (@(posedge clk) disable iff (reset)
		(fld[0][3:2] == 2'b11 && !rise[0] && !fall[0] && !st.wr_pend)
		|=> $stable(st.gr[0]))
		else $error("b captured without a pin edge");
	AST_CASCADE_UNDIV_C0: assert property (@(posedge clk) disable iff (reset)
		(fld[2][3:2] == 2'b11 && st.psc == `TPIO_PSC_UNDIV && !st.wr_pend)
		|=> $stable(st.gr[2]))
		else $error("c cascade captured on undivided clock");
	AST_BUFFER_C_HOLD: assert property (@(posedge clk) disable iff (reset)
		(st.bufa && !wf[2]) |=> $stable(pin_io.pin[2]))
		else $error("c pin moved in buffer mode");
	AST_INIT_ON_WRITE_B5: assert property (@(posedge clk) disable iff (reset)
		(wf[0] && !hwdata[7]) |=> (pin_io.pin[0] == $past(hwdata[6])))
		else $error("b initial level not applied on write");
	AST_INIT_ON_WRITE_A0: assert property (@(posedge clk) disable iff (reset)
		(wf[1] && !hwdata[3]) |=> (pin_io.pin[1] == $past(hwdata[2])))
		else $error("a initial level not applied on write");
	AST_COMPARE_NO_CAPTURE: assert property (@(posedge clk) disable iff (reset)
		(!fld[1][3] && !(st.wr_pend && st.idx == `TPIO_IDX_GR_A0))
		|=> $stable(st.gr[1]))
		else $error("compare register changed without a write");
	AST_PSC_WRITE: assert property (@(posedge clk) disable iff (reset)
		(st.wr_pend && st.idx == `TPIO_IDX_CTRL)
		|=> (st.psc == $past(hwdata[`TPIO_CTRL_PSC_HI:`TPIO_CTRL_PSC_LO])))
		else $error("prescale select not written");
	AST_BUFA_WRITE: assert property (@(posedge clk) disable iff (reset)
		(st.wr_pend && st.idx == `TPIO_IDX_CTRL)
		|=> (st.bufa == $past(hwdata[`TPIO_CTRL_BUFA])))
		else $error("buffer mode bit not written");
	AST_WRITE_NO_WAIT: assert property (@(posedge clk) disable iff (reset)
		(acc && hwrite) |=> hreadyout)
		else $error("write data phase stalled");
endmodule // tpio_top

// File: tb/tpio_pin_model.sv
// far-side pin model: outside drivers resolved against the block's enables
`timescale 1ns/100ps
module tpio_pin_model (
	// outside levels and block outputs
	input  wire logic [2:0]           ext_lvl,
	input  wire tpio_pkg::tpio_pins_s pin_io,
	// resolved wire levels
	output logic [2:0]                pin_in
);
	// the block wins where it drives, so a capture never sees its own stale level
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pin_in[i] = pin_io.oe[i] ? pin_io.pin[i] : ext_lvl[i];
		end
	end
endmodule // tpio_pin_model

// File: tb/timer_pin_io_mode_decode_tb_top.sv
// self-checking bench of the timer pin i/o decoder
`timescale 1ns/100ps
module timer_pin_io_mode_decode_tb_top;
	logic                 clk;
	logic                 reset;
	logic                 hsel;
	logic [31:0]          haddr;
	logic [1:0]           htrans;
	logic                 hwrite;
	logic [31:0]          hwdata;
	logic                 hreadyout;
	logic                 hresp;
	logic [31:0]          hrdata;
	logic [15:0]          cnt5;
	logic [15:0]          cnt0;
	logic                 tick;
	logic [2:0]           ext_lvl;
	logic [2:0]           pin_in;
	tpio_pkg::tpio_pins_s pin_io;
	integer               seed;
	integer               err_total;
	integer               comparisons;
	logic [31:0]          rd;
	logic [15:0]          c1;
	logic [15:0]          c2;

	tpio_top DUT (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .counter_ch5(cnt5),
		.counter_ch0(cnt0), .counter_ch1_tick(tick), .pin_in(pin_in), .pin_io(pin_io));
	tpio_pin_model far_side (.ext_lvl(ext_lvl), .pin_io(pin_io), .pin_in(pin_in));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_pin(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("response", 32'h0, {31'h0, hresp});
	endtask

	task automatic drive(input int ch, input logic [15:0] c, input logic l);
		@(posedge clk);
		if (ch == 0) cnt5 <= c;
		else cnt0 <= c;
		ext_lvl[ch] <= l;
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ch5 field sits in the upper nibble, ch0 fields in the lower
	function automatic logic [31:0] fd(input int ch, input logic [3:0] v);
		return (ch == 0) ? {24'h0, v, 4'h0} : {28'h0, v};
	endfunction

	function automatic logic em(input logic [2:0] v);
		return (v[1:0] == 2'h1) ? 1'b0 : (v[1:0] == 2'h2) ? 1'b1 : ~v[2];
	endfunction

	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		tally_and_finish();
	end

	initial begin
		seed = 32'h5D68;
		err_total = 0;
		comparisons = 0;
		{reset, hsel, haddr, htrans, hwrite, hwdata} = {1'b1, 68'h0};
		{cnt5, cnt0, tick, ext_lvl} = 36'h0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		bus(1'b1, 32'h1C, 32'hFFFFFFFF);
		for (int a = 0; a < 8; a++) begin
			bus(1'b0, 32'(a * 4), 32'h0);
			chk("reset value", 32'h0, rd);
		end
		$display("reset test done");
		for (int ch = 0; ch < 3; ch++) begin
			for (int v = 0; v < 8; v++) begin
				c1 = 16'($random(seed)) | 16'h0002;
				drive(ch, c1 - 16'h1, ext_lvl[ch]);
				bus(1'b1, 32'(12 + ch * 4), {16'h0, c1});
				bus(1'b1, 32'(ch * 4), fd(ch, 4'(v)));
				bus(1'b0, 32'(ch * 4), 32'h0);
				chk("field readback", fd(ch, 4'(v)), rd);
				chk_pin("enable", v % 4 != 0, pin_io.oe[ch]);
				if (v % 4 != 0) chk_pin("initial level", 1'(v / 4), pin_io.pin[ch]);
				drive(ch, c1, ext_lvl[ch]);
				repeat (3) @(posedge clk);
				if (v % 4 != 0) chk_pin("match level", em(3'(v)), pin_io.pin[ch]);
			end
		end
		bus(1'b1, 32'h18, 32'h1);
		bus(1'b1, 32'h08, 32'h1);
		repeat (2) @(posedge clk);
		chk_pin("buffered c enable", 1'b0, pin_io.oe[2]);
		bus(1'b1, 32'h08, 32'h8);
		bus(1'b1, 32'h14, 32'h0);
		drive(2, 16'h1234, 1'b1);
		repeat (5) @(posedge clk);
		bus(1'b0, 32'h14, 32'h0);
		chk("buffered c capture", 32'h0, rd);
		bus(1'b1, 32'h18, 32'h0);
		$display("compare test done");
		for (int ch = 0; ch < 3; ch++) begin
			for (int v = 8; v < 16; v++) begin
				if (ch == 0 || v < 12) begin
					c1 = {1'b0, 15'($random(seed))} | 16'h0001;
					c2 = c1 | 16'h8000;
					drive(ch, c1, 1'b0);
					bus(1'b1, 32'(ch * 4), fd(ch, 4'(v)));
					repeat (5) @(posedge clk);
					bus(1'b1, 32'(12 + ch * 4), 32'h0);
					drive(ch, c1, 1'b1);
					repeat (5) @(posedge clk);
					bus(1'b0, 32'(12 + ch * 4), 32'h0);
					chk("rise capture", (v % 4 != 1) ? {16'h0, c1} : 32'h0, rd);
					drive(ch, c2, 1'b0);
					repeat (5) @(posedge clk);
					bus(1'b0, 32'(12 + ch * 4), 32'h0);
					chk("fall capture", {16'h0, (v % 4 != 0) ? c2 : c1}, rd);
				end
			end
		end
		$display("capture test done");
		for (int ch = 1; ch < 3; ch++) begin
			for (int p = 0; p < 8; p++) begin
				c1 = 16'($random(seed)) | 16'h0001;
				bus(1'b1, 32'h18, 32'(p * 2));
				bus(1'b1, 32'(ch * 4), 32'hC);
				bus(1'b1, 32'(12 + ch * 4), 32'h0);
				drive(ch, c1, 1'b0);
				@(posedge clk);
				tick <= 1'b1;
				@(posedge clk);
				tick <= 1'b0;
				repeat (3) @(posedge clk);
				bus(1'b0, 32'(12 + ch * 4), 32'h0);
				chk("cascade capture", (p == 0) ? 32'h0 : {16'h0, c1}, rd);
			end
		end
		$display("cascade test done");
		tally_and_finish();
	end
endmodule // timer_pin_io_mode_decode_tb_top
